// ---- rtl/predriver_ctrl.v ----
// Purpose: SPI control and status logic of an H-bridge gate pre-driver
// Assumes: SPI mode 0 style: sample on rising, shift on falling SCLK edge
// Notes:   All pins are sampled by the 25 MHz clock
// What this block does
// - thermal shutdown sets flag, tristates all drivers
// - drivers stay off until soft reset clears
// - supply/overcurrent flag ORs all supply faults
// - not ready keeps gates off, pump stays on
// - standby-to-active starts settling timer first
// - not-ready clears itself after timer ends
// - identification reads return fixed words
// - leg enable pair decodes, never both on
// - active low-side freewheel: low on, high off
// - active high-side freewheel: high on, low off
// - passive freewheel switches one side off
// - overvoltage latch holds outputs off if set
// - undervoltage latch holds outputs off if set
// - writing mode one enters active mode
// - clearing mode erases registers, outputs off
// - opcode selects write, read, clear, ident
// - global status byte shifts during command
// - overcurrent latches bit, switches output off
// - supply fault deactivates outputs, latches flag
`include "predrv_map.vh"
`timescale 1ns/1ps
`default_nettype none
module predriver_ctrl #(
   parameter SETTLE_CYCLES = `SETTLE_US * `CLOCK_MHZ  // Pump settling length
) (
   // Clock and reset
   input  wire       clock,
   input  wire       rst,
   // SPI pins
   input  wire       csn,
   input  wire       sclk,
   input  wire       sdi,
   output reg        sdo,
   output wire       sdo_oe,
   // Control pins
   input  wire       enable_pin,
   input  wire       pwm,
   // Analog monitor inputs
   input  wire       thermal_event,
   input  wire       undervolt_event,
   input  wire       overvolt_event,
   input  wire [3:0] overcurrent_event,
   // Gate outputs and enables
   output reg        leg1_high_gate,
   output reg        leg1_low_gate,
   output reg        leg2_high_gate,
   output reg        leg2_low_gate,
   output reg        drivers_hiz,
   output reg        charge_pump_on
);
   localparam [15:0] SETTLE_W = SETTLE_CYCLES[15:0];  // Timer load value

   // Sync of all pins except overcurrent bits 1..0
   wire [9:0] synced;
   pin_sync #(.WIDTH(10)) u_sync (
      .clock   (clock),
      .rst     (rst),
      .pin_in  ({csn, sclk, sdi, enable_pin, pwm, thermal_event, undervolt_event,
                 overvolt_event, overcurrent_event[3:2]}),
      .pin_out (synced)
   );

   wire [1:0] oc_hi_sync;   // Overcurrent bits 1..0 synced
   pin_sync #(.WIDTH(2)) u_sync_oc (
      .clock   (clock),
      .rst     (rst),
      .pin_in  (overcurrent_event[1:0]),
      .pin_out (oc_hi_sync)
   );

   wire       s_csn  = synced[9];                // Chip select
   wire       s_sclk = synced[8];                // Serial clock
   wire       s_sdi  = synced[7];                // Serial data
   wire       s_en   = synced[6];                // Enable pin
   wire       s_pwm  = synced[5];                // PWM pin
   wire       s_tsd  = synced[4];                // Over-temperature
   wire       s_uv   = synced[3];                // Supply under-voltage
   wire       s_ov   = synced[2];                // Supply over-voltage
   wire [3:0] s_oc   = {synced[1:0], oc_hi_sync}; // HS1, LS1, HS2, LS2

   // Registers
   reg [15:0] bridge_control;          // Control register
   reg [15:0] config_word;             // Configuration register
   reg        supply_overvolt_flag;    // Latched over-voltage
   reg        supply_undervolt_flag;   // Latched under-voltage
   reg [3:0]  overcurrent_flag;        // Latched overcurrent per switch
   reg        thermal_shutdown_flag;   // Latched thermal shutdown
   reg        transfer_error_flag;     // Bad frame length seen
   reg        reset_bar_flag;          // Low after reset or stuck-at-one
   reg        not_ready_flag;          // Pump not settled
   reg [15:0] settle_count;            // Settling timer
   reg        mode_prev;               // Mode last cycle
   // SPI shifter state
   reg        sclk_prev;               // Sampled clock last cycle
   reg        csn_prev;                // Sampled select last cycle
   reg [4:0]  bit_count;               // Rising edges in frame
   reg [23:0] rx_shift;                // Received bits
   reg [23:0] tx_shift;                // Bits to send
   reg        frame_loaded;            // Transmit word captured

   wire sclk_rise = s_sclk & ~sclk_prev;  // Sampled rising edge
   wire sclk_fall = ~s_sclk & sclk_prev;  // Sampled falling edge
   wire frame_end = s_csn & ~csn_prev;    // Select released

   wire supply_or_overcurrent_flag = supply_undervolt_flag | supply_overvolt_flag |
                                     (|overcurrent_flag) | s_uv | s_ov | (|s_oc);

   wire global_fault_flag = transfer_error_flag | ~reset_bar_flag | thermal_shutdown_flag |
                            supply_or_overcurrent_flag | not_ready_flag;

   wire [7:0] global_status = {global_fault_flag, transfer_error_flag, reset_bar_flag,
                               thermal_shutdown_flag, 1'b0, supply_or_overcurrent_flag,
                               1'b0, not_ready_flag};

   wire [15:0] status_word;  // Status register view
   assign status_word = {6'h00, overcurrent_flag, 2'h0, supply_undervolt_flag,
                         supply_overvolt_flag, 2'h0};

   // Register read data chosen from the first command byte
   reg [15:0] read_word;
   always @* begin
      read_word = 16'h0000;
      if (rx_shift[6:5] == `OP_READ_IDENT) begin
         case (rx_shift[4:0] == 5'h00 ? 6'h00 : {1'b0, rx_shift[4:0]})
            default: read_word = 16'h0000;
         endcase
      end

      case ({rx_shift[6:5], rx_shift[4:0], s_sdi})
         default: read_word = 16'h0000;
      endcase

      // Decode with the full address: six bits, the last one arriving now
      if (rx_shift[6:5] == `OP_READ_IDENT) begin
         case ({rx_shift[4:0], s_sdi})
            `ADDR_IDENTIFICATION_HEADER:  read_word = `IDENTIFICATION_HEADER_VAL;
            `ADDR_ID_VERSION: read_word = `ID_VERSION_VAL;
            `ADDR_ID_CODE1:   read_word = `ID_CODE1_VAL;
            `ADDR_ID_CODE2:   read_word = `ID_CODE2_VAL;
            `ADDR_ID_FRAME:   read_word = `ID_FRAME_VAL;
            default:          read_word = 16'h0000;
         endcase
      end else begin
         case ({rx_shift[4:0], s_sdi})
            `ADDR_CONTROL: read_word = bridge_control;
            `ADDR_STATUS:  read_word = status_word;
            `ADDR_CONFIG:  read_word = config_word;
            default:       read_word = 16'h0000;
         endcase
      end
   end

   // Completed frame decode
   wire [1:0]  f_op   = rx_shift[23:22];
   wire [5:0]  f_addr = rx_shift[21:16];
   wire [15:0] f_data = rx_shift[15:0];
   wire frame_ok   = frame_end & (bit_count == `FRAME_BITS);
   wire frame_bad  = frame_end & (bit_count != `FRAME_BITS) & (bit_count != 5'd0);
   wire stuck_one  = frame_ok & (rx_shift == `STUCK_ONE);
   wire do_write   = frame_ok & ~stuck_one & (f_op == `OP_WRITE);
   wire do_clear   = frame_ok & ~stuck_one & (f_op == `OP_READ_CLEAR);
   wire [15:0] next_control = (bridge_control & ~`CTL_WMASK) | (f_data & `CTL_WMASK);
   wire mode_clear = do_write & (f_addr == `ADDR_CONTROL) & ~next_control[`CTL_MODE];
   wire soft_reset = stuck_one | mode_clear;

   // SPI shifter: sample on rising, shift out on falling
   always @(posedge clock) begin
      if (rst) begin
         sclk_prev    <= 1'b0;
         csn_prev     <= 1'b1;
         bit_count    <= 5'd0;
         rx_shift     <= 24'h000000;
         tx_shift     <= 24'h000000;
         frame_loaded <= 1'b0;
         sdo          <= 1'b0;
      end else begin
         sclk_prev <= s_sclk;
         csn_prev  <= s_csn;
         if (s_csn) begin
            // Idle: prepare next frame
            bit_count    <= 5'd0;
            frame_loaded <= 1'b0;
            tx_shift     <= {global_status, 16'h0000};
            sdo          <= global_fault_flag;
         end else begin
            if (!frame_loaded)
               sdo <= global_fault_flag;  // Fault polling before first edge
            if (sclk_rise) begin
               rx_shift <= {rx_shift[22:0], s_sdi};
               if (bit_count != 5'd31)
                  bit_count <= bit_count + 5'd1;
               if (bit_count == 5'd0) begin
                  tx_shift     <= {global_status, 16'h0000};
                  sdo          <= global_status[7];
                  frame_loaded <= 1'b1;
               end else if (bit_count == 5'd7) begin
                  tx_shift[22:7] <= read_word;  // Data half after the address
               end
            end else if (sclk_fall && frame_loaded) begin
               tx_shift <= {tx_shift[22:0], 1'b0};
               sdo      <= tx_shift[22];
            end
         end
      end
   end
   assign sdo_oe = ~s_csn;

   // Registers, flags and timer
   always @(posedge clock) begin
      if (rst) begin
         bridge_control        <= `CTL_RESET;
         config_word           <= 16'h0000;
         supply_overvolt_flag  <= 1'b0;
         supply_undervolt_flag <= 1'b0;
         overcurrent_flag      <= 4'h0;
         thermal_shutdown_flag <= 1'b0;
         transfer_error_flag   <= 1'b0;
         reset_bar_flag        <= 1'b0;
         not_ready_flag        <= 1'b1;
         settle_count          <= 16'h0000;
         mode_prev             <= 1'b0;
      end else begin
         mode_prev <= bridge_control[`CTL_MODE];

         // Transfer error, sticky until a good frame
         if (frame_bad)
            transfer_error_flag <= 1'b1;
         else if (frame_ok)
            transfer_error_flag <= 1'b0;
         if (soft_reset) begin
            bridge_control        <= `CTL_RESET;
            config_word           <= 16'h0000;
            supply_overvolt_flag  <= s_ov;                         // Set wins
            supply_undervolt_flag <= s_uv;
            overcurrent_flag      <= s_oc;
            thermal_shutdown_flag <= s_tsd;
            reset_bar_flag        <= ~stuck_one;
         end else begin
            if (do_write && f_addr == `ADDR_CONTROL) begin
               bridge_control <= next_control;
               reset_bar_flag <= 1'b1;
            end
            if (do_write && f_addr == `ADDR_CONFIG)
               config_word <= f_data & `CFG_WMASK;

            // Hardware set wins over read-and-clear
            if (do_clear && f_addr == `ADDR_STATUS) begin
               supply_overvolt_flag  <= s_ov;
               supply_undervolt_flag <= s_uv;
               overcurrent_flag      <= s_oc;
            end else begin
               supply_overvolt_flag  <= supply_overvolt_flag | s_ov;
               supply_undervolt_flag <= supply_undervolt_flag | s_uv;
               overcurrent_flag      <= overcurrent_flag | s_oc;
            end
            thermal_shutdown_flag <= thermal_shutdown_flag | s_tsd;
         end

         // Settling timer started on each entry to active mode
         if (!bridge_control[`CTL_MODE] || soft_reset) begin
            not_ready_flag <= 1'b1;
            settle_count   <= 16'h0000;
         end else if (!mode_prev) begin
            not_ready_flag <= 1'b1;
            settle_count   <= SETTLE_W;
         end else if (settle_count > 16'h0001) begin
            settle_count <= settle_count - 16'h0001;
         end else begin
            settle_count   <= 16'h0000;
            not_ready_flag <= 1'b0;
         end
      end
   end

   // Output gating and freewheel decode
   wire uv_block = supply_undervolt_flag & (s_uv | bridge_control[`CTL_UVR]);
   wire ov_block = supply_overvolt_flag & (s_ov | bridge_control[`CTL_OVR]);
   wire run_ok   = bridge_control[`CTL_MODE] & ~not_ready_flag & ~thermal_shutdown_flag &
                   ~uv_block & ~ov_block & ~s_uv & ~s_ov & reset_bar_flag & s_en;

   wire freewheel_active_select = bridge_control[`CTL_FWA];
   wire freewheel_high_select = bridge_control[`CTL_FWH];

   reg  [1:0] high_on;  // Per leg high gate request
   reg  [1:0] low_on;   // Per leg low gate request
   integer leg;
   always @* begin
      high_on = 2'b00;
      low_on  = 2'b00;
      for (leg = 0; leg < 2; leg = leg + 1) begin
         // Leg pair: bit 2*leg+7 high, 2*leg+6 low; both set means off
         high_on[leg] = bridge_control[`CTL_HS2 + 2*leg] &
                        ~bridge_control[`CTL_LS2 + 2*leg];
         low_on[leg]  = bridge_control[`CTL_LS2 + 2*leg] &
                        ~bridge_control[`CTL_HS2 + 2*leg];
         if (!s_pwm) begin
            if (freewheel_active_select && !freewheel_high_select) begin
               high_on[leg] = 1'b0;
               low_on[leg]  = high_on[leg] | low_on[leg] |
                              bridge_control[`CTL_HS2 + 2*leg] ^
                              bridge_control[`CTL_LS2 + 2*leg];
            end else if (freewheel_active_select && freewheel_high_select) begin
               low_on[leg]  = 1'b0;
               high_on[leg] = bridge_control[`CTL_HS2 + 2*leg] ^
                              bridge_control[`CTL_LS2 + 2*leg];
            end else if (!freewheel_high_select) begin
               high_on[leg] = 1'b0;
            end else begin
               low_on[leg]  = 1'b0;
            end
         end
      end
   end

   // Registered gate drives
   always @(posedge clock) begin
      if (rst) begin
         leg1_high_gate <= 1'b0;
         leg1_low_gate  <= 1'b0;
         leg2_high_gate <= 1'b0;
         leg2_low_gate  <= 1'b0;
         drivers_hiz    <= 1'b1;
         charge_pump_on <= 1'b0;
      end else begin
         leg1_high_gate <= run_ok & high_on[1] & ~overcurrent_flag[3] & ~s_oc[3];
         leg1_low_gate  <= run_ok & low_on[1]  & ~overcurrent_flag[2] & ~s_oc[2];
         leg2_high_gate <= run_ok & high_on[0] & ~overcurrent_flag[1] & ~s_oc[1];
         leg2_low_gate  <= run_ok & low_on[0]  & ~overcurrent_flag[0] & ~s_oc[0];
         drivers_hiz    <= thermal_shutdown_flag | s_tsd;
         charge_pump_on <= bridge_control[`CTL_MODE] & ~thermal_shutdown_flag &
                           ~s_tsd & reset_bar_flag;
      end
   end
endmodule // predriver_ctrl
`default_nettype wire

// ---- rtl/predrv_map.vh ----
// Purpose: Register offsets, field positions, reset values and timing of the pre-driver
// Assumes: 24-bit frames, 16-bit data words, six address bits
// Notes:   Definitions only
`ifndef PREDRV_MAP_VH
`define PREDRV_MAP_VH
// Operation codes
`define OP_WRITE        2'h0
`define OP_READ         2'h1
`define OP_READ_CLEAR   2'h2
`define OP_READ_IDENT   2'h3
// Register addresses
`define ADDR_CONTROL    6'h00
`define ADDR_STATUS     6'h10
`define ADDR_CONFIG     6'h3F
`define ADDR_IDENTIFICATION_HEADER  6'h00
`define ADDR_ID_VERSION 6'h01
`define ADDR_ID_CODE1   6'h02
`define ADDR_ID_CODE2   6'h03
`define ADDR_ID_FRAME   6'h3E
// Control fields
`define CTL_MODE        0
`define CTL_UVR         1
`define CTL_OVR         2
`define CTL_FWA         3
`define CTL_FWH         4
`define CTL_LS2         6
`define CTL_HS2         7
`define CTL_LS1         8
`define CTL_HS1         9
`define CTL_WMASK       16'h03DF
`define CTL_RESET       16'h0000
// Status fields
`define ST_SUPPLY_OVERVOLT_FLAG         2
`define ST_SUPPLY_UNDERVOLT_FLAG         3
`define ST_OC_LS2       6
`define ST_OC_HS2       7
`define ST_OC_LS1       8
`define ST_OC_HS1       9
`define CFG_WMASK       16'hFFF8
// Frame figures
`define FRAME_BITS      5'd24
`define STUCK_ONE       24'hFFFFFF
`define GSB_RESET       8'h81
// Arbitrary neutral identification values
`define IDENTIFICATION_HEADER_VAL   16'h0A01
`define ID_VERSION_VAL  16'h0001
`define ID_CODE1_VAL    16'h0A02
`define ID_CODE2_VAL    16'h0A03
`define ID_FRAME_VAL    16'h0001
// Settling time
`define SETTLE_US       100
`define CLOCK_MHZ       25
`endif

// ---- rtl/pin_sync.v ----
// Purpose: Two-stage synchroniser for a bus of pin inputs
// Assumes: Inputs asynchronous to clock
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 1  // Number of pins
) (
   // Clock and reset
   input  wire             clock,
   input  wire             rst,
   // Pins
   input  wire [WIDTH-1:0] pin_in,
   output reg  [WIDTH-1:0] pin_out
);
   reg [WIDTH-1:0] stage1;  // First stage, metastable
   // Double register
   always @(posedge clock) begin
      if (rst) begin
         stage1  <= {WIDTH{1'b0}};
         pin_out <= {WIDTH{1'b0}};
      end else begin
         stage1  <= pin_in;
         pin_out <= stage1;
      end
   end
endmodule // pin_sync
`default_nettype wire

// ---- sim/predriver_ctrl_monitor.sv ----
// Purpose: Port assertions for the pre-driver control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every predriver_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module predriver_ctrl_monitor (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Link pins
   input wire logic       csn,
   input wire logic       sdo_oe,
   // Monitor inputs
   input wire logic       thermal_event,
   input wire logic       undervolt_event,
   input wire logic       overvolt_event,
   input wire logic [3:0] overcurrent_event,
   // Driver outputs
   input wire logic       leg1_high_gate,
   input wire logic       leg1_low_gate,
   input wire logic       leg2_high_gate,
   input wire logic       leg2_low_gate,
   input wire logic       drivers_hiz,
   input wire logic       charge_pump_on
);
   logic [2:0] hot_run;  // Cycles the thermal pin stayed high
   logic [2:0] oc_run;   // Cycles the leg1 high-side fault stayed high
   logic       hot_mark; // Shutdown latched, no frame since
   logic       oc_mark;  // Fault latched, no frame since
   wire  [3:0] gates = {leg1_high_gate, leg1_low_gate, leg2_high_gate, leg2_low_gate};

   // Marks faults held long enough to latch; any frame may clear them
   always @(posedge clock) begin
      if (rst) begin
         hot_run  <= 3'h0;
         oc_run   <= 3'h0;
         hot_mark <= 1'b0;
         oc_mark  <= 1'b0;
      end else begin
         hot_run  <= thermal_event ? hot_run + {2'h0, hot_run != 3'h7} : 3'h0;
         oc_run   <= overcurrent_event[3] ? oc_run + {2'h0, oc_run != 3'h7} : 3'h0;
         hot_mark <= csn & (hot_mark | (hot_run == 3'h6));
         oc_mark  <= csn & (oc_mark | (oc_run == 3'h6));
      end
   end

   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (rst);
   // Fault pins held past the synchroniser
   sequence s_hot;
      thermal_event [*6];
   endsequence
   sequence s_supply_bad;
      (undervolt_event || overvolt_event) [*5];
   endsequence

   a_legs_exclusive: assert property (!(gates[3] && gates[2]) && !(gates[1] && gates[0]))
      else $error("both gates of one leg on");
   a_hot_tristate: assert property (s_hot |-> drivers_hiz && !charge_pump_on && gates == 4'h0)
      else $error("outputs alive during thermal shutdown");
   a_hot_sticky: assert property (hot_mark |-> drivers_hiz)
      else $error("tristate left without soft reset");
   a_hiz_pump_off: assert property (drivers_hiz [*2] |-> !charge_pump_on)
      else $error("pump on while drivers tristated");
   a_supply_off: assert property (s_supply_bad |-> gates == 4'h0)
      else $error("gates on during supply fault");
   a_oc_sticky: assert property (oc_mark |-> !leg1_high_gate)
      else $error("gate back on before fault cleared");
   a_oe_on_select: assert property ($fell(csn) |-> ##[2:4] sdo_oe)
      else $error("serial output not enabled");
   a_oe_off_idle: assert property (csn [*4] |-> !sdo_oe)
      else $error("serial output driven while idle");
endmodule // predriver_ctrl_monitor

bind predriver_ctrl predriver_ctrl_monitor predriver_ctrl_monitor_inst (
   .clock(clock), .rst(rst), .csn(csn), .sdo_oe(sdo_oe), .thermal_event(thermal_event),
   .undervolt_event(undervolt_event), .overvolt_event(overvolt_event),
   .overcurrent_event(overcurrent_event), .leg1_high_gate(leg1_high_gate),
   .leg1_low_gate(leg1_low_gate), .leg2_high_gate(leg2_high_gate),
   .leg2_low_gate(leg2_low_gate), .drivers_hiz(drivers_hiz), .charge_pump_on(charge_pump_on)
);
`default_nettype wire

// ---- sim/spi_host_model.sv ----
// Purpose: Host end of the 24-bit serial link
// Assumes: Pins move on clock rises; half period is 4 clocks
// Notes:   Idle: select high, clock and data low as pulled
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Clock
   input  wire logic clock,
   // Link pins
   output var  logic csn,
   output var  logic sclk,
   output var  logic sdi,
   input  wire logic sdo
);
   logic [23:0] rx_word; // Answer of the last frame

   // Idle levels
   initial begin
      csn = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      rx_word = 24'h000000;
   end

   // Sends nbits MSB first, samples each answer bit mid low phase
   task automatic frame(input logic [23:0] word, input int nbits);
      int i;
      @(posedge clock);
      csn <= 1'b0;
      for (i = 0; i <= nbits; i++) begin
         sdi <= (i < nbits) ? word[23-i] : 1'b0;
         repeat (2) @(posedge clock);
         #1;
         if (i > 0) rx_word[24-i] = sdo;
         repeat (2) @(posedge clock);
         if (i < nbits) begin
            sclk <= 1'b1;
            repeat (4) @(posedge clock);
            sclk <= 1'b0;
         end
      end
      csn <= 1'b1;
      repeat (10) @(posedge clock);
   endtask
endmodule // spi_host_model
`default_nettype wire

// ---- sim/predriver_ctrl_tb.sv ----
// Purpose: Self-checking bench of the pre-driver control block
// Assumes: Short pump settling time of 20 clocks
// Notes:   Link traffic goes through spi_host_model
`timescale 1ns/1ps
`default_nettype none
`include "predrv_map.vh"
module predriver_ctrl_tb;
   localparam int SETTLE = 20; // Shortened settling time
   logic       clock, rst, enable_pin, pwm;
   logic       thermal_event, undervolt_event, overvolt_event;
   logic [3:0] overcurrent_event;
   wire        csn, sclk, sdi, sdo, sdo_oe, drivers_hiz, charge_pump_on;
   wire        leg1_high_gate, leg1_low_gate, leg2_high_gate, leg2_low_gate;
   wire [15:0] gates = {12'h000, leg1_high_gate, leg1_low_gate, leg2_high_gate, leg2_low_gate};
   int         fails, tests_run;
   logic [23:0] rx; // Last frame answer

   predriver_ctrl #(.SETTLE_CYCLES(SETTLE)) predriver_ctrl_inst (.clock(clock), .rst(rst),
      .csn(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .enable_pin(enable_pin),
      .pwm(pwm), .thermal_event(thermal_event), .undervolt_event(undervolt_event),
      .overvolt_event(overvolt_event), .overcurrent_event(overcurrent_event),
      .leg1_high_gate(leg1_high_gate), .leg1_low_gate(leg1_low_gate),
      .leg2_high_gate(leg2_high_gate), .leg2_low_gate(leg2_low_gate),
      .drivers_hiz(drivers_hiz), .charge_pump_on(charge_pump_on));
   spi_host_model spi_host_model_inst (.clock(clock), .csn(csn), .sclk(sclk), .sdi(sdi),
      .sdo(sdo));

   // Word and flag comparisons
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   // One full frame, answer kept in rx
   task automatic xfer(input logic [1:0] op, input logic [5:0] adr, input logic [15:0] dat);
      spi_host_model_inst.frame({op, adr, dat}, 24);
      rx = spi_host_model_inst.rx_word;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Identification words, status after reset, short frame
   task automatic t_ident;
      logic [5:0]  adr [6] = '{`ADDR_IDENTIFICATION_HEADER, `ADDR_ID_VERSION, `ADDR_ID_CODE1,
                               `ADDR_ID_CODE2, `ADDR_ID_FRAME, 6'h04};
      logic [15:0] val [6] = '{`IDENTIFICATION_HEADER_VAL, `ID_VERSION_VAL, `ID_CODE1_VAL,
                               `ID_CODE2_VAL, `ID_FRAME_VAL, 16'h0000};
      int i;
      for (i = 0; i < 6; i++) begin
         xfer(`OP_READ_IDENT, adr[i], 16'h0000);
         if (i == 0) chk("status byte", 16'h0081, {8'h00, rx[23:16]});
         chk("ident word", val[i], rx[15:0]);
      end
      spi_host_model_inst.frame(24'h400000, 12);
      xfer(`OP_READ, `ADDR_CONTROL, 16'h0000);
      chk_bit("transfer error", 1'b1, rx[22]);
   endtask
   // Active mode waits for the pump
   task automatic t_settle;
      xfer(`OP_WRITE, `ADDR_CONTROL, 16'h0201);
      chk("gates settling", 16'h0000, gates);
      wait_clk(SETTLE + 10);
      chk("gates ready", 16'h0008, gates);
      xfer(`OP_READ, `ADDR_CONTROL, 16'h0000);
      chk("control word", 16'h0201, rx[15:0]);
      chk_bit("not ready", 1'b0, rx[16]);
      chk_bit("reset bar", 1'b1, rx[21]);
   endtask
   // Enable pairs and freewheel modes
   task automatic t_freewheel;
      logic [15:0] ctl [8] = '{16'h0301, 16'h0101, 16'h0081, 16'h0201,
                               16'h0111, 16'h0209, 16'h0119, 16'h0219};
      logic        pw [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      logic [15:0] ex [8] = '{16'h0, 16'h4, 16'h2, 16'h0, 16'h0, 16'h4, 16'h8, 16'h8};
      int i;
      for (i = 0; i < 8; i++) begin
         pwm <= pw[i];
         xfer(`OP_WRITE, `ADDR_CONTROL, ctl[i]);
         chk("leg gates", ex[i], gates);
      end
      pwm <= 1'b1;
   endtask
   // Latched and automatic supply recovery
   task automatic t_supply;
      xfer(`OP_WRITE, `ADDR_CONTROL, 16'h0203);
      undervolt_event <= 1'b1;
      wait_clk(8);
      chk("gates undervolt", 16'h0000, gates);
      xfer(`OP_READ, `ADDR_STATUS, 16'h0000);
      chk("status word", 16'h0008, rx[15:0]);
      chk_bit("supply flag", 1'b1, rx[18]);
      undervolt_event <= 1'b0;
      wait_clk(8);
      chk("gates latched", 16'h0000, gates);
      xfer(`OP_READ_CLEAR, `ADDR_STATUS, 16'h0000);
      chk("gates cleared", 16'h0008, gates);
      xfer(`OP_WRITE, `ADDR_CONTROL, 16'h0201);
      overvolt_event <= 1'b1;
      wait_clk(8);
      chk("gates overvolt", 16'h0000, gates);
      overvolt_event <= 1'b0;
      wait_clk(8);
      chk("gates recovered", 16'h0008, gates);
      xfer(`OP_READ_CLEAR, `ADDR_STATUS, 16'h0000);
      chk("status word", 16'h0004, rx[15:0]);
   endtask
   // Overcurrent stays off until cleared
   task automatic t_overcurrent;
      overcurrent_event <= 4'h8;
      wait_clk(8);
      overcurrent_event <= 4'h0;
      wait_clk(8);
      chk("gates latched", 16'h0000, gates);
      xfer(`OP_READ, `ADDR_STATUS, 16'h0000);
      chk("status word", 16'h0200, rx[15:0]);
      chk_bit("supply flag", 1'b1, rx[18]);
      xfer(`OP_READ_CLEAR, `ADDR_STATUS, 16'h0000);
      chk("gates cleared", 16'h0008, gates);
   endtask
   // Thermal shutdown and soft reset
   task automatic t_thermal;
      thermal_event <= 1'b1;
      wait_clk(10);
      chk_bit("tristate", 1'b1, drivers_hiz);
      chk_bit("pump", 1'b0, charge_pump_on);
      chk("gates hot", 16'h0000, gates);
      thermal_event <= 1'b0;
      wait_clk(8);
      chk_bit("tristate held", 1'b1, drivers_hiz);
      xfer(`OP_READ, `ADDR_CONTROL, 16'h0000);
      chk_bit("thermal flag", 1'b1, rx[20]);
      xfer(`OP_WRITE, `ADDR_CONTROL, 16'h0218);
      xfer(`OP_READ, `ADDR_CONTROL, 16'h0000);
      chk_bit("thermal flag", 1'b0, rx[20]);
      chk("control erased", 16'h0000, rx[15:0]);
      xfer(`OP_WRITE, `ADDR_CONTROL, 16'h0201);
      wait_clk(SETTLE + 10);
      chk("gates back", 16'h0008, gates);
      chk_bit("pump", 1'b1, charge_pump_on);
   endtask
   // Stuck-at-one frame forces standby
   task automatic t_stuck;
      spi_host_model_inst.frame(`STUCK_ONE, 24);
      chk("gates off", 16'h0000, gates);
      xfer(`OP_READ, `ADDR_CONTROL, 16'h0000);
      chk("control erased", 16'h0000, rx[15:0]);
      chk_bit("reset bar", 1'b0, rx[21]);
   endtask

   // Clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      enable_pin = 1'b1;
      pwm = 1'b1;
      thermal_event = 1'b0;
      undervolt_event = 1'b0;
      overvolt_event = 1'b0;
      overcurrent_event = 4'h0;
      fails = 0;
      tests_run = 0;
      wait_clk(12);
      rst <= 1'b0;
      wait_clk(4);
      t_ident();
      t_settle();
      t_freewheel();
      t_supply();
      t_overcurrent();
      t_thermal();
      t_stuck();
      finish_test();
   end
   // Watchdog
   initial begin
      wait_clk(20000);
      fails++;
      finish_test();
   end
endmodule // predriver_ctrl_tb
`default_nettype wire
